// ---- verilog/psos_top.sv ----
// Functional notes
// R01: Three 8-bit colour words, bit 7 MSB.
// R02: Sample to output latency is fixed.
// R03: Phase shifts data, clock, sync together.
// R04: Horizontal sync regenerated, aligned to clock.
// R05: Software sets sync polarity and length.
// R06: Vertical sync aligned, polarity bit selectable.
// R07: Vertical sync timing follows the source.
// R08: Green sync output: slicer or delayed sync.
// R09: Green sync output gets no other processing.
// R10: Host keeps serial clock under its maximum.
// R11: Receiver captures data with output clock.
// R12: Leading sync edge chosen by polarity bit.
// R13: All outputs change on rising clock edge.
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psos_cfg.svh"

module psos_top
    import psos_pkg::*;
(
    // System clock and reset.
    input wire logic CLK,
    input wire logic RESET_N,
    // Wishbone slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Sampling clock and converter samples.
    input wire logic LINK_CLK,
    input wire psos_pix_t RED_IN,
    input wire psos_pix_t GREEN_IN,
    input wire psos_pix_t BLUE_IN,
    // Sync pins and slicer comparator result.
    input wire logic HSYNC_IN,
    input wire logic VSYNC_IN,
    input wire logic GREEN_SYNC_IN,
    // Pixel outputs.
    output psos_pix_t RED_OUT,
    output psos_pix_t GREEN_OUT,
    output psos_pix_t BLUE_OUT,
    output logic PIXEL_OUT_CLOCK,
    output logic HSYNC_REGEN_OUT,
    output logic VSYNC_ALIGNED_OUT,
    output logic GREEN_SYNC_SLICER_OUT
);

    // Byte address decode shared by reads and writes.
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
        reg_hit = (adr == off);
    endfunction

    // Bus side state.
    logic ack_q;
    logic [31:0] dat_q;
    psos_cfg_s sh_q;
    psos_cfg_s xfer_q;
    logic dirty_q;
    logic req_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic [1:0] st_s1_q;
    logic [1:0] st_s2_q;
    logic wb_req;
    logic wr_hit;
    logic busy;
    logic launch;

    // Link side state.
    logic lrst_s1_q;
    logic link_rst_n_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    psos_cfg_s cfg_q;
    logic hs_s1_q;
    logic hs_s2_q;
    logic vs_s1_q;
    logic vs_s2_q;
    logic sg_s1_q;
    logic sg_s2_q;
    logic hs_dly_q;
    logic [1:0] lst_q;
    logic oclk_q;
    logic pix_en;
    logic hs_rg;
    psos_bundle_s b0_q;
    psos_bundle_s dl_q [`PSOS_TAPS];
    psos_bundle_s out_q;
    logic [3:0] ph_age_q;

    // A request is taken once; the registered ack closes it.
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr_hit = wb_req & WB_WE_I & WB_SEL_I[0] &
                    (reg_hit(WB_ADR_I, `PSOS_REG_CTRL) | reg_hit(WB_ADR_I, `PSOS_REG_HSW));
    assign busy = req_q ^ ack_s2_q;
    assign launch = dirty_q & ~busy;

    // Single cycle acknowledge for every address, mapped or not.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    // Read data; unmapped addresses and unused bits read as zero.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dat_q <= 32'h0000_0000;
        end else if (wb_req && !WB_WE_I) begin
            dat_q <= 32'h0000_0000;
            if (reg_hit(WB_ADR_I, `PSOS_REG_CTRL)) begin
                dat_q[`PSOS_CTRL_HSIN_POL] <= sh_q.hsin_pol;
                dat_q[`PSOS_CTRL_HSYNC_REGEN_OUT_POL] <= sh_q.hsync_regen_out_pol;
                dat_q[`PSOS_CTRL_VS_POL] <= sh_q.vs_pol;
                dat_q[`PSOS_CTRL_SOG_SEL] <= sh_q.sog_sel;
                dat_q[`PSOS_CTRL_PHASE_MSB:`PSOS_CTRL_PHASE_LSB] <= sh_q.phase;
            end else if (reg_hit(WB_ADR_I, `PSOS_REG_HSW)) begin
                dat_q[`PSOS_HSW_MSB:`PSOS_HSW_LSB] <= sh_q.width;
            end else if (reg_hit(WB_ADR_I, `PSOS_REG_STAT)) begin
                dat_q[`PSOS_STAT_BUSY] <= busy | dirty_q;
                dat_q[`PSOS_STAT_VS] <= st_s2_q[0];
                dat_q[`PSOS_STAT_HS] <= st_s2_q[1];
            end
        end
    end

    // Shadow configuration written by software; only byte lane 0 is used.
    // R05: sync polarity and length registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sh_q.hsin_pol <= `PSOS_HSIN_POL_RST;
            sh_q.hsync_regen_out_pol <= `PSOS_HSYNC_REGEN_OUT_POL_RST;
            sh_q.vs_pol <= `PSOS_VS_POL_RST;
            sh_q.sog_sel <= `PSOS_SOG_SEL_RST;
            sh_q.phase <= `PSOS_PHASE_RST;
            sh_q.width <= `PSOS_HSW_RST;
        end else if (wr_hit && reg_hit(WB_ADR_I, `PSOS_REG_CTRL)) begin
            sh_q.hsin_pol <= WB_DAT_I[`PSOS_CTRL_HSIN_POL];
            sh_q.hsync_regen_out_pol <= WB_DAT_I[`PSOS_CTRL_HSYNC_REGEN_OUT_POL];
            sh_q.vs_pol <= WB_DAT_I[`PSOS_CTRL_VS_POL];
            sh_q.sog_sel <= WB_DAT_I[`PSOS_CTRL_SOG_SEL];
            sh_q.phase <= WB_DAT_I[`PSOS_CTRL_PHASE_MSB:`PSOS_CTRL_PHASE_LSB];
        end else if (wr_hit) begin
            sh_q.width <= WB_DAT_I[`PSOS_HSW_MSB:`PSOS_HSW_LSB];
        end
    end

    // A write during a transfer is kept pending; a new write wins over the launch.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dirty_q <= 1'b0;
        end else begin
            dirty_q <= wr_hit | (dirty_q & ~launch);
        end
    end

    // Toggle handshake launch; the word is held still until the link answers.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            req_q <= 1'b0;
            xfer_q <= '0;
        end else if (launch) begin
            req_q <= ~req_q;
            xfer_q <= sh_q;
        end
    end

    // Answer toggle and status levels brought back from the link domain.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            st_s1_q <= 2'h0;
            st_s2_q <= 2'h0;
        end else begin
            ack_s1_q <= req_s3_q;
            ack_s2_q <= ack_s1_q;
            st_s1_q <= lst_q;
            st_s2_q <= st_s1_q;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    // Link reset asserts at once and releases on the link clock.
    always_ff @(posedge LINK_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lrst_s1_q <= 1'b0;
            link_rst_n_q <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            link_rst_n_q <= lrst_s1_q;
        end
    end

    // Request toggle synchroniser with a third stage for change detection.
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // Applied configuration, taken while the bus side holds the word still.
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            cfg_q.hsin_pol <= `PSOS_HSIN_POL_RST;
            cfg_q.hsync_regen_out_pol <= `PSOS_HSYNC_REGEN_OUT_POL_RST;
            cfg_q.vs_pol <= `PSOS_VS_POL_RST;
            cfg_q.sog_sel <= `PSOS_SOG_SEL_RST;
            cfg_q.phase <= `PSOS_PHASE_RST;
            cfg_q.width <= `PSOS_HSW_RST;
        end else if (req_s2_q != req_s3_q) begin
            cfg_q <= xfer_q;
        end
    end

    // Sync pins and slicer result pass two flip-flops first.
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            hs_s1_q <= 1'b0;
            hs_s2_q <= 1'b0;
            vs_s1_q <= 1'b0;
            vs_s2_q <= 1'b0;
            sg_s1_q <= 1'b0;
            sg_s2_q <= 1'b0;
            lst_q <= 2'h0;
        end else begin
            hs_s1_q <= HSYNC_IN;
            hs_s2_q <= hs_s1_q;
            vs_s1_q <= VSYNC_IN;
            vs_s2_q <= vs_s1_q;
            sg_s1_q <= GREEN_SYNC_IN;
            sg_s2_q <= sg_s1_q;
            lst_q <= {hs_s2_q, vs_s2_q};
        end
    end

    // Output clock at half the sampling rate; the tick marks its rising edge.
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            oclk_q <= 1'b0;
        end else begin
            oclk_q <= ~oclk_q;
        end
    end

    assign pix_en = ~oclk_q;

    // Horizontal sync regeneration on the pixel tick.
    psos_hs_regen u_hs_regen (
        .clk(LINK_CLK),
        .rst_n(link_rst_n_q),
        .pix_en(pix_en),
        .hs_lvl(hs_s2_q),
        .in_pol(cfg_q.hsin_pol),
        .out_pol(cfg_q.hsync_regen_out_pol),
        .width(cfg_q.width),
        .hs_out(hs_rg)
    );

    // Delayed but otherwise untouched copy of the horizontal sync input.
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            hs_dly_q <= 1'b0;
        end else if (pix_en) begin
            hs_dly_q <= hs_s2_q;
        end
    end

    // Clock bit every cycle; data and syncs only on the rising-edge tick.
    // R13: common change edge
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            b0_q <= '0;
            b0_q.hs <= `PSOS_HS_IDLE_RST;
        end else begin
            b0_q.clk <= ~oclk_q;
            if (pix_en) begin
                // R01: full 8-bit words, MSB at bit 7
                b0_q.red <= RED_IN;
                b0_q.green <= GREEN_IN;
                b0_q.blue <= BLUE_IN;
                b0_q.hs <= hs_rg;
                // R06: vertical polarity select
                // R07: vertical timing passed through
                b0_q.vs <= vs_s2_q ^ cfg_q.vs_pol;
                // R08: green sync source select
                // R09: no further processing
                b0_q.sog <= cfg_q.sog_sel ? hs_dly_q : sg_s2_q;
            end
        end
    end

    // Phase delay line moves clock, data and syncs as one word.
    // R03: common phase shift
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            for (int i = 0; i < `PSOS_TAPS; i++) begin
                dl_q[i] <= '0;
            end
        end else begin
            dl_q[0] <= b0_q;
            for (int i = 1; i < `PSOS_TAPS; i++) begin
                dl_q[i] <= dl_q[i - 1];
            end
        end
    end

    // Output register picks the tap; latency from b0_q is 2 plus the phase in link clock cycles.
    // R02: fixed pipeline depth
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            out_q <= '0;
            out_q.hs <= `PSOS_HS_IDLE_RST;
        end else begin
            out_q <= dl_q[cfg_q.phase];
        end
    end

    // Age of the phase setting, used only by the checks below.
    always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            ph_age_q <= 4'h0;
        end else if (req_s2_q != req_s3_q && xfer_q.phase != cfg_q.phase) begin
            ph_age_q <= 4'h0;
        end else if (ph_age_q != `PSOS_PH_SETTLED) begin
            ph_age_q <= ph_age_q + 4'h1;
        end
    end

    assign RED_OUT = out_q.red;
    assign GREEN_OUT = out_q.green;
    assign BLUE_OUT = out_q.blue;
    assign PIXEL_OUT_CLOCK = out_q.clk;
    assign HSYNC_REGEN_OUT = out_q.hs;
    assign VSYNC_ALIGNED_OUT = out_q.vs;
    assign GREEN_SYNC_SLICER_OUT = out_q.sog;

    a_ack_single: assert property ( // R05
        @(posedge CLK) disable iff (!RESET_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("Acknowledge held longer than one cycle.");

    a_cfg_handshake: assert property ( // R05
        @(posedge CLK) disable iff (!RESET_N)
        $rose(busy) |-> ##[1:8] !busy)
        else $error("Configuration transfer did not complete.");

    a_cfg_capture: assert property ( // R05
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (req_s2_q != req_s3_q) |=> (cfg_q == $past(xfer_q)))
        else $error("Applied configuration differs from the sent word.");

    a_outclk_toggle: assert property ( // R13
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (ph_age_q == `PSOS_PH_SETTLED) |-> (PIXEL_OUT_CLOCK != $past(PIXEL_OUT_CLOCK)))
        else $error("Output clock failed to toggle.");

    a_data_on_rise: assert property ( // R13
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (ph_age_q == `PSOS_PH_SETTLED && RED_OUT != $past(RED_OUT)) |-> PIXEL_OUT_CLOCK)
        else $error("Data changed away from the output clock rising edge.");

    a_phase_zero: assert property ( // R03
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (ph_age_q == `PSOS_PH_SETTLED && cfg_q.phase == 3'h0) |-> (out_q == $past(b0_q, 2)))
        else $error("Phase 0 delay wrong.");

    a_phase_seven: assert property ( // R02
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (ph_age_q == `PSOS_PH_SETTLED && cfg_q.phase == 3'h7) |-> (out_q == $past(b0_q, 9)))
        else $error("Phase 7 delay wrong.");

    a_vsync_follow: assert property ( // R06
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        pix_en |=> (b0_q.vs == ($past(vs_s2_q) ^ $past(cfg_q.vs_pol))))
        else $error("Vertical sync not following the input.");

    a_sog_select: assert property ( // R08
        @(posedge LINK_CLK) disable iff (!link_rst_n_q)
        pix_en |=> (b0_q.sog == ($past(cfg_q.sog_sel) ? $past(hs_dly_q) : $past(sg_s2_q))))
        else $error("Green sync output source wrong.");

endmodule
`default_nettype wire

// ---- include/psos_cfg.svh ----
`ifndef PSOS_CFG_SVH
`define PSOS_CFG_SVH

// Register byte offsets on the Wishbone slave.
`define PSOS_REG_CTRL 8'h00
`define PSOS_REG_HSW 8'h04
`define PSOS_REG_STAT 8'h08

// Field positions in the control register.
`define PSOS_CTRL_HSIN_POL 0
`define PSOS_CTRL_HSYNC_REGEN_OUT_POL 1
`define PSOS_CTRL_VS_POL 2
`define PSOS_CTRL_SOG_SEL 3
`define PSOS_CTRL_PHASE_LSB 4
`define PSOS_CTRL_PHASE_MSB 6

// Field of the pulse length register.
`define PSOS_HSW_MSB 7
`define PSOS_HSW_LSB 0

// Field positions in the status register.
`define PSOS_STAT_BUSY 0
`define PSOS_STAT_VS 1
`define PSOS_STAT_HS 2

// Reset values of the configuration fields.
`define PSOS_HSIN_POL_RST 1'b0
`define PSOS_HSYNC_REGEN_OUT_POL_RST 1'b0
`define PSOS_VS_POL_RST 1'b0
`define PSOS_SOG_SEL_RST 1'b0
`define PSOS_PHASE_RST 3'h0
`define PSOS_HSW_RST 8'h20

// Idle level of the regenerated sync while its output polarity is at reset.
`define PSOS_HS_IDLE_RST 1'b1

// Number of phase taps on the output delay line.
`define PSOS_TAPS 8
// Age at which the phase setting counts as settled.
`define PSOS_PH_SETTLED 4'hf

`endif

// ---- include/psos_pkg.sv ----
package psos_pkg;

    typedef logic [7:0] psos_pix_t;
    typedef logic [2:0] psos_phase_t;

    // Configuration that is moved across to the link domain as one word.
    typedef struct packed {
        logic hsin_pol;
        logic hsync_regen_out_pol;
        logic vs_pol;
        logic sog_sel;
        psos_phase_t phase;
        psos_pix_t width;
    } psos_cfg_s;

    // One output clock half period of everything that leaves the block.
    typedef struct packed {
        logic clk;
        psos_pix_t red;
        psos_pix_t green;
        psos_pix_t blue;
        logic hs;
        logic vs;
        logic sog;
    } psos_bundle_s;

endpackage

// ---- verilog/psos_hs_regen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "psos_cfg.svh"

module psos_hs_regen
    import psos_pkg::*;
(
    // Clock and reset of the link domain.
    input wire logic clk,
    input wire logic rst_n,
    // Pixel tick and synchronised sync level.
    input wire logic pix_en,
    input wire logic hs_lvl,
    // Configuration.
    input wire logic in_pol,
    input wire logic out_pol,
    input wire psos_pix_t width,
    // Regenerated sync.
    output logic hs_out
);

    logic prev_q;
    psos_pix_t cnt_q;
    logic out_q;
    logic lead;

    // Only the leading edge counts; its sense follows the input polarity bit.
    // R12: leading edge select
    assign lead = in_pol ? (hs_lvl & ~prev_q) : (~hs_lvl & prev_q);

    // Input history, sampled once per output clock period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else if (pix_en) begin
            prev_q <= hs_lvl;
        end
    end

    // Pulse length counter; a zero width is treated as one period.
    // R05: programmable pulse length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (pix_en) begin
            if (lead) begin
                cnt_q <= (width == 8'h00) ? 8'h01 : width;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    // Output level, re-timed to the pixel tick and set to the chosen polarity.
    // R04: re-timed regeneration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= `PSOS_HS_IDLE_RST;
        end else if (pix_en) begin
            out_q <= (lead || cnt_q > 8'h01) ? out_pol : ~out_pol;
        end
    end

    assign hs_out = out_q;

    a_hs_lead_active: assert property ( // R12
        @(posedge clk) disable iff (!rst_n)
        (pix_en && lead) |=> (hs_out == $past(out_pol)))
        else $error("Sync output not active after a leading edge.");

    a_hs_pulse_end: assert property ( // R05
        @(posedge clk) disable iff (!rst_n)
        (pix_en && !lead && cnt_q == 8'h01) |=> (hs_out == !$past(out_pol)))
        else $error("Sync pulse longer than programmed.");

endmodule
`default_nettype wire

// ---- testbench/psos_capture.sv ----
`timescale 1ns/1ps
`default_nettype none

module psos_capture
    import psos_pkg::*;
(
    // Link clock and counter clear.
    input wire logic link_clk,
    input wire logic clr,
    // Outputs of the stage under test.
    input wire logic poc,
    input wire psos_pix_t red,
    input wire psos_pix_t green,
    input wire psos_pix_t blue,
    input wire logic hs,
    input wire logic vs,
    input wire logic sog,
    // Captured words and counters.
    output psos_pix_t cap_r,
    output psos_pix_t cap_g,
    output psos_pix_t cap_b,
    output int hs_cnt,
    output int bad_cnt
);
    logic [26:0] prev;
    logic prev_poc;

    // capture on clock
    // Words and sync are taken on the falling edge, counting active sync periods.
    always @(negedge poc or posedge clr) begin
        if (clr) begin
            hs_cnt <= 0;
        end else begin
            cap_r <= red;
            cap_g <= green;
            cap_b <= blue;
            hs_cnt <= hs_cnt + int'(hs);
        end
    end

    // change edge watch
    // Any output change that does not come with a rising output clock is counted.
    always @(posedge link_clk) begin
        prev <= {red, green, blue, hs, vs, sog};
        prev_poc <= poc;
        if (clr) begin
            bad_cnt <= 0;
        end else if ({red, green, blue, hs, vs, sog} != prev && !(poc && !prev_poc)) begin
            bad_cnt <= bad_cnt + 1;
        end
    end
endmodule

`default_nettype wire

// ---- testbench/psos_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "psos_cfg.svh"

module psos_top_test
    import psos_pkg::*;
;
    // Clocks, reset and bus.
    logic CLK = 1'b0;
    logic LINK_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic WB_CYC_I = 1'b0;
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0;
    logic [31:0] WB_DAT_O;
    logic WB_ACK_O;
    // Link side.
    psos_pix_t RED_IN = 8'h00;
    psos_pix_t GREEN_IN = 8'h00;
    psos_pix_t BLUE_IN = 8'h00;
    logic HSYNC_IN = 1'b1;
    logic VSYNC_IN = 1'b0;
    logic GREEN_SYNC_IN = 1'b0;
    psos_pix_t RED_OUT, GREEN_OUT, BLUE_OUT;
    logic PIXEL_OUT_CLOCK, HSYNC_REGEN_OUT, VSYNC_ALIGNED_OUT, GREEN_SYNC_SLICER_OUT;
    // Model side and bookkeeping.
    logic clr = 1'b1;
    psos_pix_t cap_r, cap_g, cap_b;
    int hs_cnt, bad_cnt;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] rd;
    int p, s, v, n, i;
    psos_pix_t pat [3] = '{8'h80, 8'h01, 8'h5a};
    int wid [2] = '{5, 0};
    int hlen [2] = '{5, 1};

    // System clock; the host bus never runs faster than this.
    // host clock rate
    always #25 CLK = ~CLK;

    // Link clock, offset so that its edges never meet the system clock.
    initial begin
        #1.3;
        forever #3 LINK_CLK = ~LINK_CLK;
    end

    psos_top psos_top_i (.CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .LINK_CLK(LINK_CLK),
        .RED_IN(RED_IN), .GREEN_IN(GREEN_IN), .BLUE_IN(BLUE_IN), .HSYNC_IN(HSYNC_IN),
        .VSYNC_IN(VSYNC_IN), .GREEN_SYNC_IN(GREEN_SYNC_IN), .RED_OUT(RED_OUT),
        .GREEN_OUT(GREEN_OUT), .BLUE_OUT(BLUE_OUT), .PIXEL_OUT_CLOCK(PIXEL_OUT_CLOCK),
        .HSYNC_REGEN_OUT(HSYNC_REGEN_OUT), .VSYNC_ALIGNED_OUT(VSYNC_ALIGNED_OUT),
        .GREEN_SYNC_SLICER_OUT(GREEN_SYNC_SLICER_OUT));

    psos_capture psos_capture_i (.link_clk(LINK_CLK), .clr(clr), .poc(PIXEL_OUT_CLOCK),
        .red(RED_OUT), .green(GREEN_OUT), .blue(BLUE_OUT), .hs(HSYNC_REGEN_OUT),
        .vs(VSYNC_ALIGNED_OUT), .sog(GREEN_SYNC_SLICER_OUT), .cap_r(cap_r), .cap_g(cap_g),
        .cap_b(cap_b), .hs_cnt(hs_cnt), .bad_cnt(bad_cnt));

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic bus cycle, entered just after a rising edge.
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        int k;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_DAT_I <= dat;
        WB_SEL_I <= sel;
        for (k = 0; k < 50; k++) begin
            @(posedge CLK);
            if (WB_ACK_O === 1'b1) break;
        end
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CLK);
        if (k == 50) begin
            err_total++;
            end_sim();
        end
    endtask

    // Waits until the configuration has crossed, then clears the model counters.
    task automatic settle();
        int k;
        for (k = 0; k < 20; k++) begin
            wb_cycle(1'b0, `PSOS_REG_STAT, 32'h0, 4'hf);
            if (rd[`PSOS_STAT_BUSY] === 1'b0) break;
        end
        if (k == 20) begin
            err_total++;
            end_sim();
        end
        repeat (20) @(posedge CLK);
        clr <= 1'b1;
        @(posedge CLK);
        clr <= 1'b0;
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge CLK);
        chk("hsync idle in reset", HSYNC_REGEN_OUT, 32'h1); // idle level
        RESET_N <= 1'b1;
        @(posedge CLK);
        wb_cycle(1'b0, `PSOS_REG_CTRL, 32'h0, 4'hf);
        chk("ctrl reset", rd, 32'h0); // reset value
        wb_cycle(1'b0, `PSOS_REG_HSW, 32'h0, 4'hf);
        chk("width reset", rd, 32'h20); // reset value
        wb_cycle(1'b1, 8'h0c, 32'hff, 4'hf);
        wb_cycle(1'b0, 8'h0c, 32'h0, 4'hf);
        chk("unmapped read", rd, 32'h0); // unmapped place
        wb_cycle(1'b1, `PSOS_REG_HSW, 32'h7, 4'he);
        wb_cycle(1'b0, `PSOS_REG_HSW, 32'h0, 4'hf);
        chk("width byte off", rd, 32'h20); // masked write
        wb_cycle(1'b1, `PSOS_REG_CTRL, 32'hff, 4'h1);
        wb_cycle(1'b0, `PSOS_REG_CTRL, 32'h0, 4'hf);
        chk("ctrl readback", rd, 32'h7f); // field width
        $display("registers done");
        for (p = 0; p < 8; p++) begin
            wb_cycle(1'b1, `PSOS_REG_CTRL, 32'(p) << 4, 4'h1);
            settle();
            for (i = 0; i < 3; i++) begin
                RED_IN <= pat[i];
                GREEN_IN <= ~pat[i];
                BLUE_IN <= pat[i] ^ 8'h3c;
                for (n = 0; n < 40; n++) begin
                    @(posedge LINK_CLK);
                    if (RED_OUT === pat[i]) break;
                end
                chk("latency", 32'((n - p) inside {[3:4]}), 32'h1); // fixed delay
                if (n == 40) begin
                    end_sim();
                end
                repeat (2) @(posedge CLK);
                chk("red", cap_r, pat[i]); // bit order
                chk("green", cap_g, 8'(~pat[i])); // bit order
                chk("blue", cap_b, pat[i] ^ 8'h3c); // bit order
            end
            chk("change edges", bad_cnt, 32'h0); // shared edge
        end
        $display("phase done");
        for (p = 0; p < 2; p++) begin
            wb_cycle(1'b1, `PSOS_REG_CTRL, 32'(p) << 2, 4'h1);
            settle();
            for (v = 1; v >= 0; v--) begin
                VSYNC_IN <= 1'(v);
                repeat (4) @(posedge CLK);
                chk("vsync", VSYNC_ALIGNED_OUT, 32'(v ^ p)); // vsync polarity
                wb_cycle(1'b0, `PSOS_REG_STAT, 32'h0, 4'hf);
                chk("vsync status", rd[`PSOS_STAT_VS], 32'(v)); // raw level
            end
        end
        $display("vsync done");
        for (s = 0; s < 2; s++) begin
            wb_cycle(1'b1, `PSOS_REG_CTRL, 32'(s) << 3, 4'h1);
            settle();
            for (v = 0; v < 2; v++) begin
                GREEN_SYNC_IN <= 1'(v);
                HSYNC_IN <= 1'(1 - v);
                repeat (4) @(posedge CLK);
                chk("green sync out", GREEN_SYNC_SLICER_OUT, 32'(s ? 1 - v : v));
                wb_cycle(1'b0, `PSOS_REG_STAT, 32'h0, 4'hf);
                chk("hsync status", rd[`PSOS_STAT_HS], 32'(1 - v)); // raw level
            end
        end
        chk("green path edges", bad_cnt, 32'h0); // shared edge
        $display("green sync done");
        for (s = 0; s < 2; s++) begin
            HSYNC_IN <= 1'(1 - s);
            wb_cycle(1'b1, `PSOS_REG_HSW, 32'(wid[s]), 4'h1);
            wb_cycle(1'b1, `PSOS_REG_CTRL, 32'(2 + s), 4'h1);
            settle();
            chk("hsync idle", HSYNC_REGEN_OUT, 32'h0); // out polarity
            HSYNC_IN <= 1'(s);
            repeat (20) @(posedge CLK);
            chk("hsync length", hs_cnt, 32'(hlen[s])); // leading edge
            HSYNC_IN <= 1'(1 - s);
            repeat (20) @(posedge CLK);
            chk("trailing ignored", hs_cnt, 32'(hlen[s])); // trailing edge
            chk("hsync edges", bad_cnt, 32'h0); // aligned sync
        end
        $display("hsync done");
        end_sim();
    end
endmodule

`default_nettype wire
